/* File: rtl/rotary_table_axis.v */
// Rotary table output axis in virtual mode: torque limit, clutch, revolution positions.
// Assumes one tick per controller operation cycle and configuration held stable in virtual mode.
// Inputs come from logic on the same clock, so none is synchronised.
`include "rotary_axis_consts.vh"

module rotary_table_axis (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Mode and cycle
	input wire virtual_mode,
	input wire cycle_tick,
	input wire clutch_reference_set_request,
	input wire drive_is_absolute,
	input wire [`POS_W-1:0] encoder_value,
	input wire [`POS_W-1:0] pulses_per_table_revolution,
	// Torque limit source
	input wire torque_src_set,
	input wire [1:0] torque_src_area,
	input wire [`IDX_W-1:0] torque_src_index,
	input wire [`IDX_W-1:0] shared_own_points,
	input wire [`TRQ_W-1:0] torque_src_word,
	// Drive and transmission
	input wire signed [`POS_W-1:0] drive_travel,
	input wire signed [`POS_W-1:0] drive_speed,
	input wire signed [`POS_W-1:0] aux_travel,
	input wire [7:0] gear_num,
	input wire [7:0] gear_den,
	// Address mode clutch
	input wire clutch_fitted,
	input wire clutch_on_main_side,
	input wire [`POS_W-1:0] clutch_on_addr,
	input wire [`POS_W-1:0] clutch_off_addr,
	// Main and auxiliary storage locations
	input wire main_store_set,
	input wire [1:0] main_store_area,
	input wire [`IDX_W-1:0] main_store_index,
	input wire aux_store_set,
	input wire [1:0] aux_store_area,
	input wire [`IDX_W-1:0] aux_store_index,
	// Servo command
	output reg [`TRQ_W-1:0] torque_limit_q,
	output reg torque_src_error_q,
	output reg signed [`POS_W-1:0] servo_travel_q,
	output reg signed [`POS_W-1:0] servo_speed_q,
	output reg clutch_engaged_q,
	// Storage words
	output reg main_store_we_q,
	output reg [`IDX_W-1:0] main_store_addr_q,
	output reg [`POS_W-1:0] main_store_data_q,
	output reg aux_store_we_q,
	output reg [`IDX_W-1:0] aux_store_addr_q,
	output reg [`POS_W-1:0] aux_store_data_q,
	output reg store_cfg_error_q
);
	reg virtual_q;
	reg engaged_d;
	reg [`TRQ_W-1:0] torque_d;
	reg torque_ok;
	reg main_ok;
	reg aux_ok;
	wire entry;
	wire [`POS_W-1:0] main_pos;
	wire [`POS_W-1:0] aux_pos;
	wire [`POS_W-1:0] entry_val;
	wire signed [`POS_W+8:0] main_prod;
	wire signed [`POS_W+8:0] aux_prod;
	wire signed [`POS_W+8:0] spd_prod;
	wire signed [`POS_W+8:0] main_quo;
	wire signed [`POS_W+8:0] aux_quo;
	wire signed [`POS_W+8:0] spd_quo;
	wire signed [`POS_W-1:0] main_geared;
	wire signed [`POS_W-1:0] aux_geared;
	wire signed [`POS_W-1:0] spd_geared;

	// Checks one device reference against the permitted ranges of its area.
	function index_ok;
		input [1:0] area;
		input [`IDX_W-1:0] idx;
		input [`IDX_W-1:0] own_points;
		input need_even;
		begin
			index_ok = 1'b0;
			case (area)
				`AREA_DATA:
					index_ok = (idx <= `DATA_MAX);
				`AREA_LINK:
					index_ok = (idx <= `LINK_MAX);
				`AREA_MOTION:
					index_ok = (idx <= `MOTION_MAX);
				`AREA_SHARED:
					index_ok = (idx >= `SHARED_BASE) &&
						(idx < `SHARED_BASE + own_points);
				default:
					index_ok = 1'b0;
			endcase
			if (need_even && idx[0])
				index_ok = 1'b0;
		end
	endfunction

	// Storage words must avoid the block reserved for virtual axes and cams.
	function in_reserved;
		input [1:0] area;
		input [`IDX_W-1:0] idx;
		begin
			in_reserved = (area == `AREA_DATA) && (idx + 16'h0001 >= `DATA_RSV_LO) &&
				(idx <= `DATA_RSV_HI);
		end
	endfunction

	assign entry = virtual_mode && !virtual_q;
	// A reference set request restarts from zero, else absolute encoders restart from their present value; others keep the old position.
	assign entry_val = clutch_reference_set_request ? 32'h0 : encoder_value;

	// Gear ratio is num over den; a zero denominator is treated as one.
	assign main_prod = $signed(drive_travel) * $signed({1'b0, gear_num});
	assign aux_prod = $signed(aux_travel) * $signed({1'b0, gear_num});
	assign spd_prod = $signed(drive_speed) * $signed({1'b0, gear_num});
	// The quotient keeps the product width; the result is cut to a position word on purpose.
	assign main_quo = main_prod / $signed({1'b0, gear_den});
	assign aux_quo = aux_prod / $signed({1'b0, gear_den});
	assign spd_quo = spd_prod / $signed({1'b0, gear_den});
	assign main_geared = (gear_den == 8'h00) ? main_prod[`POS_W-1:0] :
		main_quo[`POS_W-1:0];
	assign aux_geared = (gear_den == 8'h00) ? aux_prod[`POS_W-1:0] :
		aux_quo[`POS_W-1:0];
	assign spd_geared = (gear_den == 8'h00) ? spd_prod[`POS_W-1:0] :
		spd_quo[`POS_W-1:0];

	rev_position_acc main_acc (
		.clk(clk),
		.rst_n(rst_n),
		.tick(virtual_mode && cycle_tick && !entry),
		.load(entry && (clutch_reference_set_request || drive_is_absolute)),
		.load_val(entry_val),
		.travel(main_geared),
		.rev_count(pulses_per_table_revolution),
		.pos_q(main_pos)
	);

	// The auxiliary side integrates whether or not the clutch is engaged.
	rev_position_acc aux_acc (
		.clk(clk),
		.rst_n(rst_n),
		.tick(virtual_mode && cycle_tick && !entry),
		.load(entry && (clutch_reference_set_request || drive_is_absolute)),
		.load_val(entry_val),
		.travel(aux_geared),
		.rev_count(pulses_per_table_revolution),
		.pos_q(aux_pos)
	);

	always @*
	begin
		torque_ok = torque_src_set && index_ok(torque_src_area, torque_src_index,
			shared_own_points, 1'b0);
		main_ok = index_ok(main_store_area, main_store_index, shared_own_points, 1'b1) &&
			!in_reserved(main_store_area, main_store_index);
		aux_ok = index_ok(aux_store_area, aux_store_index, shared_own_points, 1'b1) &&
			!in_reserved(aux_store_area, aux_store_index);
		// An out-of-range word is clamped rather than passed raw to the amplifier.
		if (!torque_ok)
			torque_d = `TORQUE_DEFAULT;
		else if (torque_src_word < `TORQUE_MIN)
			torque_d = `TORQUE_MIN;
		else if (torque_src_word > `TORQUE_MAX)
			torque_d = `TORQUE_MAX;
		else
			torque_d = torque_src_word;
		engaged_d = clutch_engaged_q;
		if (!clutch_fitted)
			engaged_d = 1'b1;
		else if (!virtual_mode)
			engaged_d = 1'b0;
		else
		begin
			// The position watched is that of the side where the clutch sits.
			if (clutch_on_main_side ? (main_pos == clutch_on_addr) : (aux_pos == clutch_on_addr))
				engaged_d = 1'b1;
			else if (clutch_on_main_side ? (main_pos == clutch_off_addr) :
				(aux_pos == clutch_off_addr))
				engaged_d = 1'b0;
		end
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			virtual_q <= 1'b0;
			torque_limit_q <= `TORQUE_DEFAULT;
			torque_src_error_q <= 1'b0;
			servo_travel_q <= 32'h0;
			servo_speed_q <= 32'h0;
			clutch_engaged_q <= 1'b0;
			main_store_we_q <= 1'b0;
			main_store_addr_q <= 16'h0;
			main_store_data_q <= 32'h0;
			aux_store_we_q <= 1'b0;
			aux_store_addr_q <= 16'h0;
			aux_store_data_q <= 32'h0;
			store_cfg_error_q <= 1'b0;
		end
		else
		begin
			virtual_q <= virtual_mode;
			torque_limit_q <= virtual_mode ? torque_d : `TORQUE_DEFAULT;
			torque_src_error_q <= torque_src_set && !torque_ok;
			clutch_engaged_q <= engaged_d;
			if (virtual_mode && cycle_tick && clutch_engaged_q)
			begin
				servo_travel_q <= main_geared;
				servo_speed_q <= spd_geared;
			end
			else
			begin
				servo_travel_q <= 32'h0;
				servo_speed_q <= 32'h0;
			end
			main_store_we_q <= virtual_mode && cycle_tick && main_store_set &&
				clutch_on_main_side && main_ok;
			main_store_addr_q <= main_store_index;
			main_store_data_q <= main_pos;
			aux_store_we_q <= virtual_mode && cycle_tick && aux_store_set && aux_ok;
			aux_store_addr_q <= aux_store_index;
			aux_store_data_q <= aux_pos;
			store_cfg_error_q <= (main_store_set && !main_ok) ||
				(aux_store_set && !aux_ok);
		end
	end
endmodule // rotary_table_axis

/* File: rtl/rotary_axis_consts.vh */
// Constants for the rotary table output axis: device index limits, torque limits and widths.
// Assumes inclusion by bare name from the axis design files and the checker.
`ifndef ROTARY_AXIS_CONSTS_VH
`define ROTARY_AXIS_CONSTS_VH

// Device areas that may hold the torque limit word or a revolution position.
`define AREA_DATA 2'h0
`define AREA_LINK 2'h1
`define AREA_MOTION 2'h2
`define AREA_SHARED 2'h3
`define DATA_MAX 16'h1fff
`define LINK_MAX 16'h1fff
`define MOTION_MAX 16'h1f3f
`define DATA_RSV_LO 16'h0320
`define DATA_RSV_HI 16'h0617
`define SHARED_BASE 16'h2710

// Torque limit in percent.
`define TORQUE_DEFAULT 11'h12c
`define TORQUE_MIN 11'h001
`define TORQUE_MAX 11'h3e8

// Widths.
`define POS_W 32
`define TRQ_W 11
`define IDX_W 16

`endif

/* File: rtl/rev_position_acc.v */
// Revolution position accumulator: keeps a position within one table revolution.
// Assumes travel per cycle is smaller in magnitude than the revolution count.
`include "rotary_axis_consts.vh"

module rev_position_acc (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Control
	input wire tick,
	input wire load,
	input wire [`POS_W-1:0] load_val,
	input wire signed [`POS_W-1:0] travel,
	input wire [`POS_W-1:0] rev_count,
	// Result
	output reg [`POS_W-1:0] pos_q
);
	reg [`POS_W-1:0] pos_d;
	reg signed [`POS_W+1:0] sum;

	always @*
	begin
		sum = $signed({2'h0, pos_q}) + {{2{travel[`POS_W-1]}}, travel};
		pos_d = pos_q;
		if (load)
		begin
			if (load_val >= rev_count)
				pos_d = load_val % rev_count;
			else
				pos_d = load_val;
		end
		else if (tick)
		begin
			// Wrap in both directions so the value never leaves its range.
			if (sum < 0)
				pos_d = sum[`POS_W-1:0] + rev_count;
			else if (sum >= $signed({2'h0, rev_count}))
				pos_d = sum[`POS_W-1:0] - rev_count;
			else
				pos_d = sum[`POS_W-1:0];
		end
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pos_q <= 32'h0;
		else
			pos_q <= pos_d;
	end
endmodule // rev_position_acc

/* File: sim/rotary_axis_asserts.sv */
// Checker for the rotary table axis outputs.
// Assumes it is bound to rotary_table_axis and sees its ports only.
`include "rotary_axis_consts.vh"
module rotary_axis_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic virtual_mode,
	input wire logic cycle_tick,
	input wire logic clutch_fitted,
	input wire logic torque_src_set,
	input wire logic [`POS_W-1:0] pulses_per_table_revolution,
	input wire logic [`TRQ_W-1:0] torque_limit_q,
	input wire logic signed [`POS_W-1:0] servo_travel_q,
	input wire logic clutch_engaged_q,
	input wire logic main_store_we_q,
	input wire logic [`IDX_W-1:0] main_store_addr_q,
	input wire logic [`POS_W-1:0] main_store_data_q,
	input wire logic aux_store_we_q,
	input wire logic [`POS_W-1:0] aux_store_data_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	real_default_a: assert property (!virtual_mode |=> torque_limit_q == 11'h12c)
		else $error("limit not default outside virtual mode");
	virt_default_a: assert property (virtual_mode && !torque_src_set |=> torque_limit_q == 11'h12c)
		else $error("limit not default without source");
	limit_range_a: assert property (torque_limit_q >= 11'h001 && torque_limit_q <= 11'h3e8)
		else $error("limit out of range");
	idle_travel_a: assert property (!cycle_tick |=> servo_travel_q == 32'h0)
		else $error("travel without tick");
	main_range_a: assert property (main_store_we_q |-> main_store_data_q < pulses_per_table_revolution)
		else $error("main position out of range");
	aux_range_a: assert property (aux_store_we_q |-> aux_store_data_q < pulses_per_table_revolution)
		else $error("aux position out of range");
	even_addr_a: assert property (main_store_we_q |-> !main_store_addr_q[0])
		else $error("odd storage address written");
	no_clutch_a: assert property (virtual_mode && !clutch_fitted |=> clutch_engaged_q)
		else $error("unclutched axis not engaged");
	cover property (main_store_we_q);
	cover property ($rose(virtual_mode));
	cover property (cycle_tick ##1 servo_travel_q != 32'h0);
endmodule // rotary_axis_asserts

bind rotary_table_axis rotary_axis_asserts u_rotary_axis_asserts (.clk(clk), .rst_n(rst_n),
	.virtual_mode(virtual_mode), .cycle_tick(cycle_tick), .clutch_fitted(clutch_fitted),
	.torque_src_set(torque_src_set), .pulses_per_table_revolution(pulses_per_table_revolution),
	.torque_limit_q(torque_limit_q), .servo_travel_q(servo_travel_q),
	.clutch_engaged_q(clutch_engaged_q), .main_store_we_q(main_store_we_q),
	.main_store_addr_q(main_store_addr_q), .main_store_data_q(main_store_data_q),
	.aux_store_we_q(aux_store_we_q), .aux_store_data_q(aux_store_data_q));

/* File: sim/servo_amp_model.sv */
// Servo amplifier model: integrates commanded travel into a motor position.
// Assumes travel stands for one cycle per operation tick.
module servo_amp_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command
	input wire logic signed [31:0] travel,
	input wire logic [10:0] torque,
	// Motor
	output logic signed [31:0] motor_pos
);
	timeunit 1ns;
	timeprecision 1ns;
	// A zero torque limit would hold the motor, so travel is then lost.
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			motor_pos <= 0;
		else if (torque != 0)
			motor_pos <= motor_pos + travel;
endmodule // servo_amp_model

/* File: sim/rotary_table_axis_tb_top.sv */
// Testbench for the rotary table axis: torque limit, positions and storage.
// Assumes the servo model on the travel output and the bound checker.
module rotary_table_axis_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ND = 10;
	logic clk = 0, rst_n = 0, vm = 0, tk = 0, rf = 0, ab = 0, tset = 0, cfit = 0, cmain = 1;
	logic aset = 1, pushm = 1;
	logic [1:0] tarea = 0, marea = 0, aarea = 0;
	logic [15:0] tidx = 0, midx = 16'h0010, aidx = 16'h0020, son = 16'h0004;
	logic [10:0] tword = 0, trq;
	logic signed [31:0] dt = 0, at = 0, enc = 0, spos, stv;
	logic [31:0] con = 0, coff = 0, mdat, adat;
	logic mwe, awe, cerr, ceng, terr;
	int pm = 0, pa = 0, mot = 0, err_count = 0, check_count = 0;
	int qm[$], qa[$];
	rotary_table_axis u_rotary_table_axis (.clk(clk), .rst_n(rst_n), .virtual_mode(vm),
		.cycle_tick(tk), .clutch_reference_set_request(rf), .drive_is_absolute(ab),
		.encoder_value(enc), .pulses_per_table_revolution(32'(ND)), .torque_src_set(tset),
		.torque_src_area(tarea), .torque_src_index(tidx), .shared_own_points(son),
		.torque_src_word(tword), .drive_travel(dt), .drive_speed(dt), .aux_travel(at),
		.gear_num(8'h03), .gear_den(8'h02), .clutch_fitted(cfit), .clutch_on_main_side(cmain),
		.clutch_on_addr(con), .clutch_off_addr(coff), .main_store_set(1'b1),
		.main_store_area(marea), .main_store_index(midx), .aux_store_set(aset),
		.aux_store_area(aarea), .aux_store_index(aidx), .torque_limit_q(trq),
		.torque_src_error_q(terr), .servo_travel_q(stv), .servo_speed_q(),
		.clutch_engaged_q(ceng),
		.main_store_we_q(mwe), .main_store_addr_q(), .main_store_data_q(mdat),
		.aux_store_we_q(awe), .aux_store_addr_q(), .aux_store_data_q(adat),
		.store_cfg_error_q(cerr));
	servo_amp_model u_servo_amp_model (.clk(clk), .rst_n(rst_n), .travel(stv), .torque(trq),
		.motor_pos(spos));
	initial forever #10 clk = ~clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic trq_case(input logic s, input logic [1:0] a, input logic [15:0] i,
		input logic [10:0] w, input logic [10:0] e);
		@(posedge clk);
		tset <= s;
		tarea <= a;
		tidx <= i;
		tword <= w;
		repeat (2) @(posedge clk);
		@(negedge clk) chk(trq, e);
		chk(terr, s && e == 11'h12c);
	endtask
	// Configuration only changes while out of virtual mode, as the axis expects.
	task automatic enter(input logic r, input logic b, input int e);
		@(posedge clk);
		vm <= 0;
		repeat (2) @(posedge clk);
		rf <= r;
		ab <= b;
		enc <= e;
		vm <= 1;
		@(posedge clk);
		if (r || b)
		begin
			pm = r ? 0 : e % ND;
			pa = pm;
		end
	endtask
	task automatic tick(input int t, input int a);
		@(posedge clk);
		if (pushm)
			qm.push_back(pm);
		qa.push_back(pa);
		pm = (pm + t * 3 / 2 + ND) % ND;
		pa = (pa + a * 3 / 2 + ND) % ND;
		mot += t * 3 / 2;
		tk <= 1;
		dt <= t;
		at <= a;
		@(posedge clk);
		tk <= 0;
	endtask
	function automatic int rnd();
		return int'($urandom_range(4)) * 2 - 4;
	endfunction
	// Outputs are read half a cycle after the edge that launches them.
	always @(negedge clk)
	begin
		if (mwe)
			chk(mdat, qm.size() ? qm.pop_front() : -1);
		if (awe)
			chk(adat, qa.size() ? qa.pop_front() : -1);
	end
	initial
	begin
		void'($urandom(45990));
		repeat (20) @(posedge clk);
		rst_n <= 1;
		@(negedge clk) chk(trq, 11'h12c);
		enter(1, 0, 0);
		trq_case(1, 0, 16'h1fff, 11'h1f4, 11'h1f4);
		trq_case(1, 1, 16'h1fff, 11'h3e8, 11'h3e8);
		trq_case(1, 2, 16'h1f3f, 11'h001, 11'h001);
		trq_case(1, 2, 16'h1f40, 11'h1f4, 11'h12c);
		trq_case(0, 0, 16'h0000, 11'h1f4, 11'h12c);
		$display("test torque done");
		repeat (12) tick(rnd(), rnd());
		enter(0, 0, 0);
		repeat (6) tick(rnd(), rnd());
		enter(0, 1, 23);
		repeat (4) tick(rnd(), rnd());
		enter(1, 0, 0);
		repeat (3) tick(rnd(), rnd());
		$display("test positions done");
		pushm = 0;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			vm <= 0;
			marea <= (i == 2) ? 2'h3 : 2'h0;
			midx <= (i == 0) ? 16'h0011 : (i == 1) ? 16'h0320 : 16'h2714;
			enter(0, 0, 0);
			repeat (2) tick(rnd(), rnd());
			chk(cerr, 1);
		end
		@(posedge clk);
		vm <= 0;
		marea <= 0;
		midx <= 16'h0010;
		pushm = 1;
		enter(0, 0, 0);
		repeat (2) tick(rnd(), rnd());
		// Clutch from address 0 to address 6; travel stops once it releases.
		@(posedge clk);
		vm <= 0;
		cfit <= 1;
		con <= 0;
		coff <= 6;
		enter(1, 0, 0);
		repeat (2) tick(2, 0);
		@(negedge clk) chk(ceng, 1);
		tick(2, 0);
		mot -= 3;
		@(negedge clk) chk(ceng, 0);
		$display("test clutch done");
		repeat (4) @(posedge clk);
		chk(cerr, 0);
		chk(spos, mot);
		chk(qm.size() + qa.size(), 0);
		$display("test storage done");
		print_verdict();
	end
	initial
	begin
		#1000000;
		err_count++;
		print_verdict();
	end
endmodule // rotary_table_axis_tb_top
